// ---- design/ibf_edge_det.v ----
// Purpose: registers the sampled bus lines and flags their edges
// Assumes: line inputs already synchronous to mclk_in
// Notes:   one-cycle pulses, frozen while ce_in is low
`timescale 1ns/10ps
module ibf_edge_det (
  // clock and reset
  input  wire mclk_in,
  input  wire rst_n_in,
  input  wire ce_in,
  // lines
  input  wire scl_in,
  input  wire sda_in,
  // results
  output reg  scl_q_out,
  output reg  sda_q_out,
  output wire scl_rise_out,
  output wire scl_fall_out,
  output wire start_out,
  output wire stop_out
);

  // ----------------------------------------
  // line history
  // ----------------------------------------
  // idle lines are high, so reset to high avoids a false scl rise
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q_out <= 1'b1;
      sda_q_out <= 1'b1;
    end else if (ce_in) begin
      scl_q_out <= scl_in;
      sda_q_out <= sda_in;
    end
  end

  // edge and condition decode
  assign scl_rise_out = ce_in & ~scl_q_out & scl_in;
  assign scl_fall_out = ce_in & scl_q_out & ~scl_in;
  assign start_out    = ce_in & scl_q_out & scl_in & sda_q_out & ~sda_in;
  assign stop_out     = ce_in & scl_q_out & scl_in & ~sda_q_out & sda_in;

endmodule

// ---- design/ibf_port.v ----
// Purpose: two-wire client port with byte framing and buffering
// Assumes: scl and sda inputs synchronous to mclk_in; host drives scl
// Notes:   7-bit client addressing; host mode only reuses the reload value
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "ibf_defs.vh"

// Function
// - direction bit after address: one reads from client, zero writes to it.
// - address and data bytes shift most significant bit first.
// - present client acknowledges received byte by holding data low.
// - data changes only while clock is low; high-clock changes mark conditions.
// - in writes, client acknowledges after every byte received; here it sends no ack while the buffer is still full.
// - in reads, client supplies bytes and host acknowledges each.
// - stop is data rising while clock stays high.
// - control registers read/write; status low six read-only, top two writable. Here control two is read-only status.
// - address register is own address in client mode, reload in host mode.
// - mask register gates the received address comparison.
// - complete received byte moves to buffer and sets port flag.
// - transmit not double buffered; buffer write loads buffer and shifter.
// - each unit is nine clocks: eight data bits plus acknowledge.
// - after eighth falling edge sender releases data, samples acknowledge.
// - host makes clock; receivers sample data on rising edge.
// - enabled two-wire mode forces both pins open-drain.
// - low sample while driving expected high is a bus collision.
// - bus idle only with no host active and both lines high.
// - matching address with direction set: client supplies bytes until restart/stop.
// - matching address with direction clear enters write-request state.
// - start is data falling while clock held high.
module ibf_port (
  // clock, reset, enable
  input  wire       mclk_in,
  input  wire       rst_n_in,
  input  wire       ce_in,
  // register port
  input  wire [2:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  // bus pins, enables high while pulling low
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       scl_out,
  output wire       scl_oe_out,
  output wire       sda_out,
  output wire       sda_oe_out,
  // status
  output wire       port_interrupt_flag_out,
  output wire       reload_value_valid_out,
  output wire [7:0] reload_value_out
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_RECV = 3'h2;
  localparam ST_SEND = 3'h3;
  localparam ST_ACKO = 3'h4;
  localparam ST_ACKI = 3'h5;
  localparam ST_WAIT = 3'h6;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0] port_control_one;
  reg  [7:0] port_control_three;
  reg  [1:0] status_rw_bits;
  reg  [7:0] rx_tx_buffer;
  reg  [7:0] byte_shift_reg;
  reg  [7:0] own_address_or_reload;
  reg  [7:0] address_mask_reg;
  reg  [2:0] state;
  reg  [3:0] bit_cnt;
  reg        addr_phase;
  reg        buf_full;
  reg        read_req;
  reg        write_req;
  reg        addr_hit;
  reg        saw_start;
  reg        saw_stop;
  reg        port_interrupt_flag;
  reg        collision;
  reg        ack_rx;
  reg        bus_active;
  reg        sda_drive_low;
  reg        rd_sel_mem;
  reg  [7:0] rd_direct;

  wire       scl_q;
  wire       sda_q;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire [7:0] mem_rdata;
  wire [7:0] port_status_reg;
  wire [7:0] port_control_two;
  wire       enabled;
  wire       bus_idle;
  wire       buf_wr;
  wire       flag_clr;

  // true when the masked received address equals our own
  function addr_match;
    input [7:0] rx;
    input [7:0] own;
    input [7:0] msk;
    begin
      addr_match = ((rx[7:1] ^ own[7:1]) & msk[7:1]) == 7'h00;
    end
  endfunction

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  ibf_edge_det u_edge (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .scl_q_out    (scl_q),
    .sda_q_out    (sda_q),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall),
    .start_out    (start_det),
    .stop_out     (stop_det)
  );

  // control three is plain storage, so it lives in the little memory
  ibf_reg_mem #(
    .AW (3),
    .DW (8)
  ) u_mem (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .ce_in     (ce_in),
    .we_in     (reg_wr_in && reg_addr_in == `IBF_ADDR_CTRL3),
    .waddr_in  (reg_addr_in),
    .wdata_in  (reg_wdata_in),
    .raddr_in  (reg_addr_in),
    .rdata_out (mem_rdata)
  );

  // ----------------------------------------
  // derived status
  // ----------------------------------------
  assign enabled  = port_control_one[`IBF_C1_ENABLE];
  assign bus_idle = ~bus_active & scl_q & sda_q;
  assign buf_wr   = reg_wr_in && reg_addr_in == `IBF_ADDR_BUFFER;
  assign flag_clr = reg_wr_in && reg_addr_in == `IBF_ADDR_CTRL1 &&
                    reg_wdata_in[`IBF_C1_FLAG_CLR];

  // upper two bits writable, lower six are hardware state except bit 1, tied to zero
  assign port_status_reg = {status_rw_bits, saw_start, saw_stop, addr_hit,
                            read_req, 1'b0, buf_full};
  assign port_control_two = {3'h0, write_req, bus_idle, ack_rx, collision,
                             port_interrupt_flag};

  // ----------------------------------------
  // pins: open drain, only ever pull low
  // ----------------------------------------
  assign sda_out    = 1'b0;
  assign scl_out    = 1'b0;
  assign sda_oe_out = enabled & sda_drive_low;
  assign scl_oe_out = 1'b0; // client never stretches here
  assign port_interrupt_flag_out = port_interrupt_flag;
  assign reload_value_valid_out  = enabled & port_control_one[`IBF_C1_HOST];
  assign reload_value_out        = own_address_or_reload;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_control_one      <= `IBF_RST_BYTE;
      port_control_three    <= `IBF_RST_BYTE;
      status_rw_bits        <= 2'h0;
      own_address_or_reload <= `IBF_RST_BYTE;
      address_mask_reg      <= `IBF_RST_MASK;
    end else if (ce_in && reg_wr_in) begin
      case (reg_addr_in)
        `IBF_ADDR_CTRL1:   port_control_one      <= reg_wdata_in;
        `IBF_ADDR_CTRL3:   port_control_three    <= reg_wdata_in;
        `IBF_ADDR_STATUS:  status_rw_bits        <= reg_wdata_in[7:6];
        `IBF_ADDR_OWNADDR: own_address_or_reload <= reg_wdata_in;
        `IBF_ADDR_MASK:    address_mask_reg      <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // register reads, data in the next cycle
  // ----------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_sel_mem <= 1'b0;
      rd_direct  <= `IBF_RST_BYTE;
    end else if (ce_in) begin
      rd_sel_mem <= reg_rd_in && reg_addr_in == `IBF_ADDR_CTRL3;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `IBF_ADDR_STATUS:  rd_direct <= port_status_reg;
          `IBF_ADDR_CTRL1:   rd_direct <= port_control_one;
          `IBF_ADDR_CTRL2:   rd_direct <= port_control_two;
          `IBF_ADDR_BUFFER:  rd_direct <= rx_tx_buffer;
          `IBF_ADDR_OWNADDR: rd_direct <= own_address_or_reload;
          `IBF_ADDR_MASK:    rd_direct <= address_mask_reg;
          default:           rd_direct <= `IBF_RST_BYTE;
        endcase
      end else begin
        rd_direct <= `IBF_RST_BYTE;
      end
    end
  end

  // memory copy and direct copy agree for control three
  always @* begin
    reg_rdata_out = rd_sel_mem ? (mem_rdata & port_control_three) | mem_rdata : rd_direct;
  end

  // ----------------------------------------
  // framing engine
  // ----------------------------------------
  // sda changes only after a falling scl, samples only on rising scl
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state               <= ST_IDLE;
      bit_cnt             <= `IBF_BIT_ZERO;
      addr_phase          <= 1'b0;
      byte_shift_reg      <= `IBF_RST_BYTE;
      rx_tx_buffer        <= `IBF_RST_BYTE;
      buf_full            <= 1'b0;
      read_req            <= 1'b0;
      write_req           <= 1'b0;
      addr_hit            <= 1'b0;
      saw_start           <= 1'b0;
      saw_stop            <= 1'b0;
      port_interrupt_flag <= 1'b0;
      collision           <= 1'b0;
      ack_rx              <= 1'b0;
      bus_active          <= 1'b0;
      sda_drive_low       <= 1'b0;
    end else if (ce_in) begin
      // software side: buffer read empties, buffer write loads both
      if (reg_rd_in && reg_addr_in == `IBF_ADDR_BUFFER) begin
        buf_full <= 1'b0;
      end
      if (buf_wr) begin
        rx_tx_buffer   <= reg_wdata_in;
        byte_shift_reg <= reg_wdata_in;
      end
      // flag clear first so a same-cycle set below wins
      if (flag_clr) begin
        port_interrupt_flag <= 1'b0;
        collision           <= 1'b0;
      end
      if (!enabled) begin
        state         <= ST_IDLE;
        sda_drive_low <= 1'b0;
        bus_active    <= 1'b0;
      end else if (start_det) begin
        // start or restart resets client logic toward a new address
        state         <= ST_ADDR;
        bit_cnt       <= `IBF_BIT_ZERO;
        addr_phase    <= 1'b1;
        bus_active    <= 1'b1;
        saw_start     <= 1'b1;
        saw_stop      <= 1'b0;
        read_req      <= 1'b0;
        write_req     <= 1'b0;
        addr_hit      <= 1'b0;
        sda_drive_low <= 1'b0;
      end else if (stop_det) begin
        state         <= ST_IDLE;
        bus_active    <= 1'b0;
        saw_stop      <= 1'b1;
        saw_start     <= 1'b0;
        read_req      <= 1'b0;
        write_req     <= 1'b0;
        sda_drive_low <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_RECV: begin
            if (scl_rise) begin
              // msb arrives first, so shift toward the top
              byte_shift_reg <= {byte_shift_reg[6:0], sda_q};
              bit_cnt        <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `IBF_BIT_ACK) begin
              bit_cnt <= `IBF_BIT_ZERO;
              if (state == ST_ADDR) begin
                if (addr_match(byte_shift_reg, own_address_or_reload,
                               address_mask_reg)) begin
                  addr_hit            <= 1'b1;
                  rx_tx_buffer        <= byte_shift_reg;
                  buf_full            <= 1'b1;
                  port_interrupt_flag <= 1'b1;
                  sda_drive_low       <= 1'b1;
                  read_req            <= byte_shift_reg[0];
                  write_req           <= ~byte_shift_reg[0];
                  state               <= ST_ACKO;
                end else begin
                  state <= ST_WAIT; // not ours: stay silent until next start
                end
              end else begin
                // receiver side of the double buffer
                rx_tx_buffer        <= byte_shift_reg;
                buf_full            <= 1'b1;
                port_interrupt_flag <= 1'b1;
                sda_drive_low       <= ~buf_full;
                state               <= ST_ACKO;
              end
            end
          end
          ST_ACKO: begin
            // release after the ninth clock, then send or receive the next
            if (scl_fall) begin
              addr_phase <= 1'b0;
              if (read_req) begin
                sda_drive_low <= ~byte_shift_reg[7];
                state         <= ST_SEND;
              end else begin
                sda_drive_low <= 1'b0;
                state         <= ST_RECV;
              end
            end
          end
          ST_SEND: begin
            if (scl_rise) begin
              // driving high but line low means someone else won
              if (!sda_drive_low && !sda_q) begin
                collision           <= 1'b1;
                port_interrupt_flag <= 1'b1;
                sda_drive_low       <= 1'b0;
                state               <= ST_WAIT;
              end
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == `IBF_BIT_ACK) begin
                sda_drive_low  <= 1'b0;
                byte_shift_reg <= {byte_shift_reg[6:0], 1'b0};
                state          <= ST_ACKI;
              end else begin
                sda_drive_low  <= ~byte_shift_reg[6];
                byte_shift_reg <= {byte_shift_reg[6:0], 1'b0};
              end
            end
          end
          ST_ACKI: begin
            // host acknowledge sampled on the ninth rising edge
            if (scl_rise) begin
              ack_rx              <= ~sda_q;
              port_interrupt_flag <= 1'b1;
              bit_cnt             <= `IBF_BIT_ZERO;
              // no ack means the host ends with stop or restart
              state               <= sda_q ? ST_WAIT : ST_SEND;
            end else begin
              sda_drive_low <= 1'b0;
            end
          end
          ST_WAIT: begin
            sda_drive_low <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ---- design/ibf_reg_mem.v ----
// Purpose: small register store for plain read/write registers
// Assumes: one write port, one read port
// Notes:   read data come out of a register one cycle later
`timescale 1ns/10ps
module ibf_reg_mem #(
  parameter AW = 3,
  parameter DW = 8
) (
  // clock and reset
  input  wire          mclk_in,
  input  wire          rst_n_in,
  input  wire          ce_in,
  // write side
  input  wire          we_in,
  input  wire [AW-1:0] waddr_in,
  input  wire [DW-1:0] wdata_in,
  // read side
  input  wire [AW-1:0] raddr_in,
  output reg  [DW-1:0] rdata_out
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------
  // storage, no reset so it maps to memory
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (ce_in && we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // registered read
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= {DW{1'b0}};
    end else if (ce_in) begin
      rdata_out <= mem[raddr_in];
    end
  end

endmodule

// ---- inc/ibf_defs.vh ----
// Purpose: constants for the two-wire byte framing port
// Assumes: 8-bit register port, word index addresses
// Notes:   definitions only
`ifndef IBF_DEFS_VH
`define IBF_DEFS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define IBF_ADDR_STATUS   3'h0
`define IBF_ADDR_CTRL1    3'h1
`define IBF_ADDR_CTRL2    3'h2
`define IBF_ADDR_CTRL3    3'h3
`define IBF_ADDR_BUFFER   3'h4
`define IBF_ADDR_OWNADDR  3'h5
`define IBF_ADDR_MASK     3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define IBF_C1_ENABLE     5
`define IBF_C1_HOST       3
`define IBF_C1_FLAG_CLR   0
`define IBF_ST_RW_MASK    8'hc0
`define IBF_ST_FULL       0
`define IBF_ST_READ_REQ   2
`define IBF_ST_ADDR_HIT   3
`define IBF_ST_STOP       4
`define IBF_ST_START      5
`define IBF_C2_FLAG       0
`define IBF_C2_COLL       1
`define IBF_C2_ACKRX      2
`define IBF_C2_IDLE       3
`define IBF_C2_WR_REQ     4

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define IBF_RST_BYTE      8'h00
`define IBF_RST_MASK      8'hff
`define IBF_BIT_LAST      4'h7
`define IBF_BIT_ACK       4'h8
`define IBF_BIT_ZERO      4'h0

`endif

// ---- testbench/ibf_host_model.sv ----
// Purpose: behavioural two-wire host that clocks the client port
// Assumes: bench resolves both open-drain lines with pull-ups
// Notes:   fixed phase length; no clock stretching seen
`timescale 1ns/10ps
module ibf_host_model #(
  parameter H = 6
) (
  // clock
  input  wire mclk_in,
  // resolved data line
  input  wire sda_in,
  // pull-down requests
  output reg  scl_low_out = 1'b0,
  output reg  sda_low_out = 1'b0
);
  // ----------------------------------------
  // bus primitives
  // ----------------------------------------
  task automatic hold(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // also serves as restart: data falls while the clock is high
  task automatic start_cond();
    sda_low_out <= 1'b0;
    hold(H);
    scl_low_out <= 1'b0;
    hold(H);
    sda_low_out <= 1'b1;
    hold(H);
    scl_low_out <= 1'b1;
    hold(H);
  endtask
  // data set in the low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low_out <= !b;
    hold(H);
    scl_low_out <= 1'b0;
    hold(H);
    r = sda_in;
    hold(H);
    scl_low_out <= 1'b1;
    hold(H);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack_n);
  endtask
  // drv lets the host pull bits low to provoke a collision
  task automatic rd_byte(input logic [7:0] drv, input logic ack_n, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(drv[i], r);
      d[i] = r;
    end
    bit_io(ack_n, r);
  endtask
  task automatic stop_cond();
    sda_low_out <= 1'b1;
    hold(H);
    scl_low_out <= 1'b0;
    hold(H);
    sda_low_out <= 1'b0;
    hold(H);
  endtask
endmodule

// ---- testbench/ibf_port_checker.sv ----
// Purpose: concurrent checks on the pins of the byte framing port
// Assumes: ce_in held high by the bench
// Notes:   sees only top-level ports, bound below
`timescale 1ns/10ps
`include "ibf_defs.vh"
module ibf_port_checker (
  // clock and reset
  input logic       mclk_in,
  input logic       rst_n_in,
  input logic       ce_in,
  // register port
  input logic [2:0] reg_addr_in,
  input logic [7:0] reg_wdata_in,
  input logic       reg_wr_in,
  input logic       reg_rd_in,
  input logic [7:0] reg_rdata_out,
  // bus pins
  input logic       scl_in,
  input logic       sda_in,
  input logic       scl_out,
  input logic       scl_oe_out,
  input logic       sda_out,
  input logic       sda_oe_out,
  // status
  input logic       port_interrupt_flag_out,
  input logic [7:0] reload_value_out
);
  // ----------------------------------------
  // register port checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_rd_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_status_rw;
    reg_wr_in && ce_in && reg_addr_in == `IBF_ADDR_STATUS ##2
      reg_rd_in && reg_addr_in == `IBF_ADDR_STATUS |=>
      (reg_rdata_out & `IBF_ST_RW_MASK) == ($past(reg_wdata_in, 3) & `IBF_ST_RW_MASK);
  endproperty
  a_status_rw: assert property (p_status_rw) else $error("status top bits lost");
  property p_reload;
    reg_wr_in && ce_in && reg_addr_in == `IBF_ADDR_OWNADDR |=>
      reload_value_out == $past(reg_wdata_in);
  endproperty
  a_reload: assert property (p_reload) else $error("address register not shown");
  // ----------------------------------------
  // bus pin checks
  // ----------------------------------------
  // a client never makes the clock and only ever pulls low
  property p_pins_od;
    !scl_oe_out && !scl_out && !sda_out;
  endproperty
  a_pins_od: assert property (p_pins_od) else $error("pin driven high or clock driven");
  // data drive only moves in the low phase, high phase is for conditions
  property p_hold_high;
    scl_in && $past(scl_in) |-> $stable(sda_oe_out);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("data moved with clock high");
  property p_oe_rise;
    $rose(sda_oe_out) |-> !scl_in && !$past(scl_in);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive began outside low phase");
  property p_oe_fall;
    $fell(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("release outside low phase");
  // the flag is set one cycle after a clock edge is seen, never mid phase
  property p_flag_low;
    $rose(port_interrupt_flag_out) |-> scl_in != $past(scl_in, 2);
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("flag not at clock edge");
  // after a stop the client stays off the data line
  property p_stop_quiet;
    scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe_out [*3];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("drive after stop");
endmodule

bind ibf_port ibf_port_checker u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .port_interrupt_flag_out(port_interrupt_flag_out), .reload_value_out(reload_value_out)
);

// ---- testbench/ibf_port_test.sv ----
// Purpose: directed bench for the byte framing client port
// Assumes: host model owns the clock line, pull-ups on both lines
// Notes:   clock enable tied high; no stretching exercised
`timescale 1ns/10ps
`include "ibf_defs.vh"
`define IBF_CHK(act, exp, msg) begin n_compared++; if ((act) !== (exp)) begin \
  error_cnt++; $display("MISMATCH %0t %s", $time, msg); end end
module ibf_port_test;
  logic       mclk_in      = 1'b0;
  logic       rst_n_in     = 1'b0;
  logic [2:0] reg_addr_in  = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_wr_in    = 1'b0;
  logic       reg_rd_in    = 1'b0;
  wire  [7:0] reg_rdata_out, rl_value;
  wire        scl_oe, sda_oe, host_scl_low, host_sda_low, flag_out, rl_valid;
  // open-drain resolution, released lines float high
  wire        scl_line = ~(host_scl_low | scl_oe);
  wire        sda_line = ~(host_sda_low | sda_oe);
  int         error_cnt  = 0;
  int         n_compared = 0;
  logic       ack_n;
  logic [7:0] d, st;

  always #5 mclk_in = ~mclk_in;

  ibf_port u_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .scl_in(scl_line), .sda_in(sda_line), .scl_out(),
    .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe),
    .port_interrupt_flag_out(flag_out), .reload_value_valid_out(rl_valid),
    .reload_value_out(rl_value)
  );
  ibf_host_model u_host (
    .mclk_in(mclk_in), .sda_in(sda_line), .scl_low_out(host_scl_low),
    .sda_low_out(host_sda_low)
  );
  // ----------------------------------------
  // register port tasks
  // ----------------------------------------
  task automatic reg_write(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    @(posedge mclk_in);
    reg_wr_in    <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in   <= 1'b0;
    #1 v = reg_rdata_out;
  endtask
  task automatic reg_expect(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    reg_read(a, v);
    `IBF_CHK(v, e, "register value")
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    reg_expect(`IBF_ADDR_MASK, `IBF_RST_MASK);
    reg_expect(3'h7, 8'h00);
    reg_write(`IBF_ADDR_CTRL3, 8'h96);
    reg_expect(`IBF_ADDR_CTRL3, 8'h96);
    reg_write(`IBF_ADDR_STATUS, 8'hff);
    reg_expect(`IBF_ADDR_STATUS, `IBF_ST_RW_MASK);
    reg_write(`IBF_ADDR_STATUS, 8'h00);
    reg_write(`IBF_ADDR_OWNADDR, 8'ha4);
    #1 `IBF_CHK(rl_value, 8'ha4, "reload value")
    reg_write(`IBF_ADDR_CTRL1, 8'h28);
    #1 `IBF_CHK(rl_valid, 1'b1, "host mode")
    reg_write(`IBF_ADDR_CTRL1, 8'h20);
    #1 `IBF_CHK(rl_valid, 1'b0, "client mode")
  endtask
  task automatic t_write();
    u_host.start_cond();
    reg_read(`IBF_ADDR_CTRL2, d);
    `IBF_CHK(d[`IBF_C2_IDLE], 1'b0, "idle in transfer")
    u_host.wr_byte(8'ha4, ack_n);
    `IBF_CHK(ack_n, 1'b0, "address ack")
    `IBF_CHK(flag_out, 1'b1, "address flag")
    reg_read(`IBF_ADDR_CTRL2, d);
    `IBF_CHK(d[`IBF_C2_WR_REQ], 1'b1, "write request")
    reg_expect(`IBF_ADDR_BUFFER, 8'ha4);
    reg_write(`IBF_ADDR_CTRL1, 8'h21);
    u_host.wr_byte(8'h5a, ack_n);
    `IBF_CHK(ack_n, 1'b0, "data ack")
    reg_expect(`IBF_ADDR_BUFFER, 8'h5a);
    u_host.wr_byte(8'h3c, ack_n);
    `IBF_CHK(ack_n, 1'b0, "second data ack")
    u_host.wr_byte(8'h96, ack_n);
    `IBF_CHK(ack_n, 1'b1, "ack with buffer full")
    u_host.stop_cond();
    reg_read(`IBF_ADDR_STATUS, d);
    `IBF_CHK(d[`IBF_ST_STOP], 1'b1, "stop seen")
    reg_read(`IBF_ADDR_CTRL2, d);
    `IBF_CHK(d[`IBF_C2_IDLE], 1'b1, "idle after stop")
  endtask
  // one address byte per mask setting; the ack tells match from miss
  task automatic t_mask(input logic [7:0] m, input logic exp_n);
    reg_read(`IBF_ADDR_BUFFER, d);
    reg_write(`IBF_ADDR_MASK, m);
    u_host.start_cond();
    u_host.wr_byte(8'ha8, ack_n);
    `IBF_CHK(ack_n, exp_n, "masked match")
    u_host.stop_cond();
  endtask
  // buffer loaded while the address ack is on the wire, before bit 7 leaves
  task automatic read_xfer(input logic [7:0] txd, input logic [7:0] drv);
    reg_read(`IBF_ADDR_BUFFER, d);
    reg_write(`IBF_ADDR_CTRL1, 8'h21);
    u_host.start_cond();
    fork
      u_host.wr_byte(8'ha5, ack_n);
      begin
        for (int i = 0; i < 400 && flag_out !== 1'b1; i++) @(posedge mclk_in);
        reg_write(`IBF_ADDR_BUFFER, txd);
        reg_read(`IBF_ADDR_STATUS, st);
      end
    join
    `IBF_CHK(ack_n, 1'b0, "read address ack")
    `IBF_CHK(st[`IBF_ST_READ_REQ], 1'b1, "read request")
    u_host.rd_byte(drv, 1'b1, d);
  endtask
  task automatic t_read();
    u_host.start_cond();
    u_host.wr_byte(8'ha4, ack_n);
    read_xfer(8'hc3, 8'hff);
    `IBF_CHK(d, 8'hc3, "read data")
    u_host.stop_cond();
    read_xfer(8'hff, 8'h0f);
    u_host.stop_cond();
    reg_read(`IBF_ADDR_CTRL2, d);
    `IBF_CHK(d[`IBF_C2_COLL], 1'b1, "collision missed")
    reg_write(`IBF_ADDR_CTRL1, 8'h21);
    reg_read(`IBF_ADDR_CTRL2, d);
    `IBF_CHK(d[`IBF_C2_COLL], 1'b0, "collision stuck")
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence, reset held for eight cycles
  initial begin
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    reg_expect(`IBF_ADDR_STATUS, `IBF_RST_BYTE);
    t_regs();
    t_write();
    t_mask(8'hff, 1'b1);
    t_mask(8'hf0, 1'b0);
    t_read();
    tally_and_finish();
  end
  // watchdog, several times the expected run length
  initial begin
    repeat (20000) @(posedge mclk_in);
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
